/* logic/locr_aux_mux.v */
`timescale 1ns/1ns
`include "locr_consts.vh"

module locr_aux_mux #(
  parameter W = 10
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // select
  input  wire [2:0]   sel,
  // sources
  input  wire [W-1:0] src_input,
  input  wire [W-1:0] src_analog_supply,
  input  wire [W-1:0] src_bias_out,
  input  wire [W-1:0] src_mod_out,
  input  wire [W-1:0] src_bias_dac,
  input  wire [W-1:0] src_mod_dac,
  input  wire [W-1:0] src_fault_dac,
  // result
  output reg  [W-1:0] result_q
);

reg [W-1:0] result_d;

always @* begin
  case (sel)
    `LOCR_AUX_INPUT:         result_d = src_input;
    `LOCR_AUX_ANALOG_SUPPLY: result_d = src_analog_supply;
    `LOCR_AUX_BIAS_OUT:      result_d = src_bias_out;
    `LOCR_AUX_MOD_OUT:       result_d = src_mod_out;
    `LOCR_AUX_BIAS_DAC:      result_d = src_bias_dac;
    `LOCR_AUX_MOD_DAC:       result_d = src_mod_dac;
    `LOCR_AUX_FAULT_DAC:     result_d = src_fault_dac;
    // reserved code reports zero
    default:                 result_d = {W{1'b0}};
  endcase
end

always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    result_q <= {W{1'b0}};
  end else begin
    result_q <= result_d;
  end
end

endmodule // locr_aux_mux

/* logic/locr_consts.vh */
`ifndef LOCR_CONSTS_VH
`define LOCR_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define LOCR_ADDR_OUT_MON      8'h00
`define LOCR_ADDR_BIAS_LOOP    8'h01

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LOCR_OUT_MON_RST       8'h00
`define LOCR_BIAS_LOOP_RST     8'h02
`define LOCR_READ_ZERO         8'h00

// ----------------------------------------------------------------------------
// output_and_monitor_config fields
// ----------------------------------------------------------------------------
`define LOCR_OM_SOFT_RESET     7
`define LOCR_OM_GP_STATE       6
`define LOCR_OM_DIODE_FAULT    5
`define LOCR_OM_OUT_ENABLE     4
`define LOCR_OM_MOD_REF        3
`define LOCR_OM_AUX_HI         2
`define LOCR_OM_AUX_LO         0

// ----------------------------------------------------------------------------
// bias_loop_config fields
// ----------------------------------------------------------------------------
`define LOCR_BL_INVERT         7
`define LOCR_BL_GAIN           6
`define LOCR_BL_REF            5
`define LOCR_BL_FBR_HI         4
`define LOCR_BL_FBR_LO         2
`define LOCR_BL_DRIVE_DIR      1
`define LOCR_BL_SHUT_POL       0

// ----------------------------------------------------------------------------
// auxiliary voltage select codes
// ----------------------------------------------------------------------------
`define LOCR_AUX_INPUT         3'h0
`define LOCR_AUX_ANALOG_SUPPLY 3'h1
`define LOCR_AUX_BIAS_OUT      3'h2
`define LOCR_AUX_MOD_OUT       3'h3
`define LOCR_AUX_BIAS_DAC      3'h4
`define LOCR_AUX_MOD_DAC       3'h5
`define LOCR_AUX_FAULT_DAC     3'h6

`endif

/* logic/locr_nv_store.v */
`timescale 1ns/1ns
`include "locr_consts.vh"

module locr_nv_store (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // control
  input  wire       load_req,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // nonvolatile array side
  input  wire [7:0] nv_rd_data,
  output reg        nv_wr_en,
  output reg  [7:0] nv_wr_data,
  // working copy
  output reg  [7:0] cfg_q
);

// ----------------------------------------------------------------------------
// working copy, reloaded from the array after every reset
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    cfg_q      <= `LOCR_BIAS_LOOP_RST;
    nv_wr_en   <= 1'b0;
    nv_wr_data <= `LOCR_BIAS_LOOP_RST;
  end else begin
    nv_wr_en <= wr_en;
    if (wr_en) begin
      cfg_q      <= wr_data;
      nv_wr_data <= wr_data;
    end else if (load_req) begin
      cfg_q <= nv_rd_data;
    end
  end
end

endmodule // locr_nv_store

/* logic/locr_regs.v */
// Notes on behaviour
// - writing one to bit 7 resets device
// - general mode: state bit drives open-drain pin
// - reset pulse mode ignores output state bit
// - bit 5 reads diode fault flag
// - output enable gates shutdown, modulation, bias
// - bit 3 picks modulation reference
// - aux select routes source to result
// - bias register write aborts, restarts conversion
// - bias register kept in nonvolatile storage
// - bias register needs valid OEM password
// - bit 7 swaps loop amplifier inputs
// - bit 6 picks quarter or full swing
// - bit 5 picks loop reference rail
// - bits 4..2 select feedback resistor
// - bit 1 sets source or sink drive
// - bit 0 sets shutdown output polarity
// - first register at 0x00, resets 0x00
`timescale 1ns/1ns
`include "locr_consts.vh"

module locr_regs #(
  parameter VW = 10
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // byte register port from the serial interface engine
  input  wire          reg_wr_en,
  input  wire          reg_rd_en,
  input  wire [7:0]    reg_addr,
  input  wire [7:0]    reg_wr_data,
  output reg  [7:0]    reg_rd_data,
  output reg           reg_rd_valid,
  output wire          reg_refused,
  input  wire          oem_password_ok,
  // device-wide soft reset
  output wire          soft_reset_pulse,
  // general purpose open-drain pin
  input  wire          gp_output_mode_select,
  input  wire          reset_pulse_drive_low,
  output wire          gp_open_drain_pin_o,
  output wire          gp_open_drain_pin_oe,
  // diode fault from the temperature sensor
  input  wire          diode_fault_in,
  // laser outputs
  input  wire          shutdown_request,
  output reg           laser_shutdown_output_o,
  output wire          laser_shutdown_output_oe,
  output wire          modulation_output_oe,
  output wire          bias_output_oe,
  output wire          modulation_reference_select,
  // bias loop controls
  output wire          loop_inversion_bit,
  output wire          bias_gain_quarter,
  output wire          loop_reference_select,
  output wire [2:0]    feedback_resistor_select,
  output wire          drive_direction_bit,
  output wire          shutdown_polarity_bit,
  // converter sequence
  output reg           adc_abort_pulse,
  output reg           adc_restart_pulse,
  // nonvolatile array for the bias register
  input  wire [7:0]    nv_rd_data,
  output wire          nv_wr_en,
  output wire [7:0]    nv_wr_data,
  // auxiliary voltage sources and result
  input  wire [VW-1:0] src_input,
  input  wire [VW-1:0] src_analog_supply,
  input  wire [VW-1:0] src_bias_out,
  input  wire [VW-1:0] src_mod_out,
  input  wire [VW-1:0] src_bias_dac,
  input  wire [VW-1:0] src_mod_dac,
  input  wire [VW-1:0] src_fault_dac,
  output wire [VW-1:0] reported_voltage_result
);

// ----------------------------------------------------------------------------
// reset values of output_and_monitor_config fields
// ----------------------------------------------------------------------------
localparam [7:0] OM_RST         = `LOCR_OUT_MON_RST;
localparam       GP_STATE_RST   = OM_RST[`LOCR_OM_GP_STATE];
localparam       OUT_ENABLE_RST = OM_RST[`LOCR_OM_OUT_ENABLE];
localparam       MOD_REF_RST    = OM_RST[`LOCR_OM_MOD_REF];
localparam [2:0] AUX_SEL_RST    = OM_RST[`LOCR_OM_AUX_HI:`LOCR_OM_AUX_LO];

// ----------------------------------------------------------------------------
// declarations
// ----------------------------------------------------------------------------
reg        gp_output_state_q;
reg        output_enable_q;
reg        mod_ref_q;
reg  [2:0] aux_voltage_select_q;
reg        soft_rst_q;
reg        boot_load_q;
reg        booted_q;
reg        fault_meta_q;
reg        diode_fault_flag_q;
reg  [7:0] rd_data_d;
wire [7:0] bias_loop_config;
wire       hit_out_mon;
wire       hit_bias;
wire       wr_out_mon;
wire       wr_bias;
wire       soft_reset_req;
wire       nv_load;
wire       shutdown_active;

// ----------------------------------------------------------------------------
// address decode and password gate
// ----------------------------------------------------------------------------
assign hit_out_mon = (reg_addr == `LOCR_ADDR_OUT_MON);
assign hit_bias    = (reg_addr == `LOCR_ADDR_BIAS_LOOP);
assign wr_out_mon  = reg_wr_en & hit_out_mon;
// bias register only reachable once the password is accepted
assign wr_bias     = reg_wr_en & hit_bias & oem_password_ok;
assign reg_refused = (reg_wr_en | reg_rd_en) & hit_bias & ~oem_password_ok;

// ----------------------------------------------------------------------------
// soft reset
// ----------------------------------------------------------------------------
// writing zero to the reset bit does nothing
assign soft_reset_req   = wr_out_mon & reg_wr_data[`LOCR_OM_SOFT_RESET];
// pulse also leaves the block so the rest of the device restarts
assign soft_reset_pulse = soft_rst_q;

always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    soft_rst_q <= 1'b0;
  end else begin
    soft_rst_q <= soft_reset_req;
  end
end

// ----------------------------------------------------------------------------
// nonvolatile reload after power-up or soft reset
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    booted_q    <= 1'b0;
    boot_load_q <= 1'b0;
  end else begin
    booted_q    <= 1'b1;
    boot_load_q <= ~booted_q;
  end
end

// soft reset reloads the stored byte rather than the default
assign nv_load = boot_load_q | soft_rst_q;

// ----------------------------------------------------------------------------
// output_and_monitor_config
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    gp_output_state_q    <= GP_STATE_RST;
    output_enable_q      <= OUT_ENABLE_RST;
    mod_ref_q            <= MOD_REF_RST;
    aux_voltage_select_q <= AUX_SEL_RST;
  end else if (soft_rst_q) begin
    // same state as after power-up
    gp_output_state_q    <= GP_STATE_RST;
    output_enable_q      <= OUT_ENABLE_RST;
    mod_ref_q            <= MOD_REF_RST;
    aux_voltage_select_q <= AUX_SEL_RST;
  end else if (wr_out_mon && !soft_reset_req) begin
    gp_output_state_q    <= reg_wr_data[`LOCR_OM_GP_STATE];
    output_enable_q      <= reg_wr_data[`LOCR_OM_OUT_ENABLE];
    mod_ref_q            <= reg_wr_data[`LOCR_OM_MOD_REF];
    aux_voltage_select_q <= reg_wr_data[`LOCR_OM_AUX_HI:`LOCR_OM_AUX_LO];
  end
end

// ----------------------------------------------------------------------------
// diode fault synchroniser
// ----------------------------------------------------------------------------
// fault pin is asynchronous to clk_sys
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    fault_meta_q       <= 1'b0;
    diode_fault_flag_q <= 1'b0;
  end else begin
    fault_meta_q       <= diode_fault_in;
    diode_fault_flag_q <= fault_meta_q;
  end
end

// ----------------------------------------------------------------------------
// bias_loop_config in nonvolatile storage
// ----------------------------------------------------------------------------
locr_nv_store u_bias_store (
  .clk_sys    (clk_sys),
  .rst_n      (rst_n),
  .load_req   (nv_load),
  .wr_en      (wr_bias),
  .wr_data    (reg_wr_data),
  .nv_rd_data (nv_rd_data),
  .nv_wr_en   (nv_wr_en),
  .nv_wr_data (nv_wr_data),
  .cfg_q      (bias_loop_config)
);

assign loop_inversion_bit       = bias_loop_config[`LOCR_BL_INVERT];
assign bias_gain_quarter        = bias_loop_config[`LOCR_BL_GAIN];
assign loop_reference_select    = bias_loop_config[`LOCR_BL_REF];
assign feedback_resistor_select = bias_loop_config[`LOCR_BL_FBR_HI:`LOCR_BL_FBR_LO];
assign drive_direction_bit      = bias_loop_config[`LOCR_BL_DRIVE_DIR];
assign shutdown_polarity_bit    = bias_loop_config[`LOCR_BL_SHUT_POL];

// ----------------------------------------------------------------------------
// converter abort and restart
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    adc_abort_pulse   <= 1'b0;
    adc_restart_pulse <= 1'b0;
  end else begin
    // abort as the write lands, restart once it has completed
    adc_abort_pulse   <= wr_bias;
    adc_restart_pulse <= adc_abort_pulse;
  end
end

// ----------------------------------------------------------------------------
// general purpose open-drain pin
// ----------------------------------------------------------------------------
// pin is only ever pulled low; high means released
assign gp_open_drain_pin_o  = 1'b0;
assign gp_open_drain_pin_oe = gp_output_mode_select ? reset_pulse_drive_low
                                                    : ~gp_output_state_q;

// ----------------------------------------------------------------------------
// laser output stage
// ----------------------------------------------------------------------------
// shutdown level follows the request through the polarity bit
assign shutdown_active             = shutdown_polarity_bit ? shutdown_request
                                                           : ~shutdown_request;
assign laser_shutdown_output_oe    = output_enable_q;
assign modulation_output_oe        = output_enable_q;
assign bias_output_oe              = output_enable_q;
assign modulation_reference_select = mod_ref_q;

always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    laser_shutdown_output_o <= 1'b0;
  end else begin
    laser_shutdown_output_o <= shutdown_active;
  end
end

// ----------------------------------------------------------------------------
// auxiliary voltage routing
// ----------------------------------------------------------------------------
// result lags the select by one register stage
locr_aux_mux #(
  .W (VW)
) u_aux_mux (
  .clk_sys           (clk_sys),
  .rst_n             (rst_n),
  .sel               (aux_voltage_select_q),
  .src_input         (src_input),
  .src_analog_supply (src_analog_supply),
  .src_bias_out      (src_bias_out),
  .src_mod_out       (src_mod_out),
  .src_bias_dac      (src_bias_dac),
  .src_mod_dac       (src_mod_dac),
  .src_fault_dac     (src_fault_dac),
  .result_q          (reported_voltage_result)
);

// ----------------------------------------------------------------------------
// read path
// ----------------------------------------------------------------------------
// locked bias reads fall through to zero
always @* begin
  rd_data_d = `LOCR_READ_ZERO;
  if (hit_out_mon) begin
    // reset bit is write only and reads zero
    rd_data_d[`LOCR_OM_GP_STATE]                    = gp_output_state_q;
    rd_data_d[`LOCR_OM_DIODE_FAULT]                 = diode_fault_flag_q;
    rd_data_d[`LOCR_OM_OUT_ENABLE]                  = output_enable_q;
    rd_data_d[`LOCR_OM_MOD_REF]                     = mod_ref_q;
    rd_data_d[`LOCR_OM_AUX_HI:`LOCR_OM_AUX_LO]      = aux_voltage_select_q;
  end else if (hit_bias && oem_password_ok) begin
    rd_data_d = bias_loop_config;
  end
end

always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    reg_rd_data  <= `LOCR_READ_ZERO;
    reg_rd_valid <= 1'b0;
  end else begin
    reg_rd_valid <= reg_rd_en;
    if (reg_rd_en) begin
      reg_rd_data <= rd_data_d;
    end
  end
end

endmodule // locr_regs

/* verif/locr_nv_model.sv */
`timescale 1ns/1ns
module locr_nv_model #(
  parameter [7:0] INIT = 8'h02
) (
  // clock
  input  wire       clk_sys,
  // array port
  input  wire       nv_wr_en,
  input  wire [7:0] nv_wr_data,
  output reg  [7:0] nv_rd_data
);
  initial nv_rd_data = INIT;
  // array keeps its byte across every reset
  always @(posedge clk_sys) begin
    if (nv_wr_en) begin
      nv_rd_data <= nv_wr_data;
    end
  end
endmodule // locr_nv_model

/* verif/locr_regs_checker.sv */
`timescale 1ns/1ns
module locr_regs_checker (
  // clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // register port
  input wire       reg_wr_en,
  input wire       reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data,
  input wire       reg_rd_valid,
  input wire       reg_refused,
  input wire       oem_password_ok,
  // outputs watched
  input wire       soft_reset_pulse,
  input wire       gp_output_mode_select,
  input wire       reset_pulse_drive_low,
  input wire       gp_open_drain_pin_oe,
  input wire       bias_output_oe,
  input wire       modulation_output_oe,
  input wire       loop_inversion_bit,
  input wire [2:0] feedback_resistor_select,
  input wire       shutdown_polarity_bit,
  input wire       adc_abort_pulse,
  input wire       adc_restart_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ------------
  // sequences
  // ------------
  sequence bias_wr_s;
    reg_wr_en && reg_addr == 8'h01 && oem_password_ok;
  endsequence
  sequence cfg0_wr_s;
    reg_wr_en && reg_addr == 8'h00 && !reg_wr_data[7];
  endsequence
  // ------------
  // assertions
  // ------------
  conv_restart_a: assert property (bias_wr_s |=> adc_abort_pulse ##1 adc_restart_pulse)
    else $error("bias write without abort and restart");
  refuse_flag_a: assert property ((reg_wr_en || reg_rd_en) && reg_addr == 8'h01 && !oem_password_ok
    |-> reg_refused)
    else $error("locked access not refused");
  refused_read_a: assert property (reg_rd_en && reg_addr == 8'h01 && !oem_password_ok
    |=> reg_rd_valid && reg_rd_data == 8'h00)
    else $error("locked read returned data");
  soft_reset_a: assert property (reg_wr_en && reg_addr == 8'h00 && reg_wr_data[7]
    |=> soft_reset_pulse ##1 !soft_reset_pulse)
    else $error("soft reset pulse wrong");
  pulse_mode_a: assert property (gp_output_mode_select |-> gp_open_drain_pin_oe == reset_pulse_drive_low)
    else $error("pin not following pulse mode");
  gp_state_a: assert property (cfg0_wr_s ##1 !gp_output_mode_select
    |-> gp_open_drain_pin_oe == !$past(reg_wr_data[6]))
    else $error("pin not following state bit");
  out_enable_a: assert property (cfg0_wr_s |=> bias_output_oe == $past(reg_wr_data[4])
    && modulation_output_oe == $past(reg_wr_data[4]))
    else $error("output enable wrong");
  loop_bits_a: assert property (bias_wr_s |=> {loop_inversion_bit, feedback_resistor_select, shutdown_polarity_bit}
    == {$past(reg_wr_data[7]), $past(reg_wr_data[4:2]), $past(reg_wr_data[0])})
    else $error("loop fields wrong");
endmodule // locr_regs_checker

bind locr_regs locr_regs_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
  .reg_rd_valid(reg_rd_valid), .reg_refused(reg_refused), .oem_password_ok(oem_password_ok),
  .soft_reset_pulse(soft_reset_pulse), .gp_output_mode_select(gp_output_mode_select),
  .reset_pulse_drive_low(reset_pulse_drive_low), .gp_open_drain_pin_oe(gp_open_drain_pin_oe),
  .bias_output_oe(bias_output_oe), .modulation_output_oe(modulation_output_oe),
  .loop_inversion_bit(loop_inversion_bit), .feedback_resistor_select(feedback_resistor_select),
  .shutdown_polarity_bit(shutdown_polarity_bit), .adc_abort_pulse(adc_abort_pulse),
  .adc_restart_pulse(adc_restart_pulse));

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  reg        clk_sys, rst_n, wr_en, rd_en, pwd, mode, rpl, fault_in, shreq;
  reg  [7:0] addr, wdata, d;
  reg  [9:0] src [0:6];
  wire [7:0] rdata, nvrd, nvwd;
  wire [9:0] result;
  wire [2:0] fb_res;
  wire       rvalid, gpo, gpoe, shut_o, shut_oe, mod_oe, bias_oe, mod_ref, loop_inv, gq, lref, ddir, shut_pol, nvwe;
  integer    fail_count, checks_done, cyc, i;

  locr_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rvalid), .reg_refused(), .oem_password_ok(pwd),
    .soft_reset_pulse(), .gp_output_mode_select(mode), .reset_pulse_drive_low(rpl), .gp_open_drain_pin_o(gpo),
    .gp_open_drain_pin_oe(gpoe), .diode_fault_in(fault_in), .shutdown_request(shreq),
    .laser_shutdown_output_o(shut_o), .laser_shutdown_output_oe(shut_oe), .modulation_output_oe(mod_oe),
    .bias_output_oe(bias_oe), .modulation_reference_select(mod_ref), .loop_inversion_bit(loop_inv),
    .bias_gain_quarter(gq), .loop_reference_select(lref), .feedback_resistor_select(fb_res),
    .drive_direction_bit(ddir), .shutdown_polarity_bit(shut_pol), .adc_abort_pulse(), .adc_restart_pulse(),
    .nv_rd_data(nvrd), .nv_wr_en(nvwe), .nv_wr_data(nvwd), .src_input(src[0]), .src_analog_supply(src[1]),
    .src_bias_out(src[2]), .src_mod_out(src[3]), .src_bias_dac(src[4]), .src_mod_dac(src[5]),
    .src_fault_dac(src[6]), .reported_voltage_result(result));
  locr_nv_model nv_u (.clk_sys(clk_sys), .nv_wr_en(nvwe), .nv_wr_data(nvwd), .nv_rd_data(nvrd));

  // ------------
  // helpers
  // ------------
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clk_sys);
      wr_en = 1'b1;
      addr = a;
      wdata = v;
      @(negedge clk_sys);
      wr_en = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk_sys);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk_sys);
      rd_en = 1'b0;
      chk("rd_valid", rvalid, 1'b1);
      chk("rd_data", rdata, e);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end

  // ------------
  // tests
  // ------------
  initial begin
    {rst_n, wr_en, rd_en, pwd, mode, rpl, fault_in, shreq} = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    fail_count = 0;
    checks_done = 0;
    cyc = 0;
    for (i = 0; i < 7; i = i + 1) src[i] = 10'h100 | i;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd(8'h00, 8'h00);
    rd(8'h05, 8'h00);
    fault_in = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd(8'h00, 8'h20);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h00);
    pwd = 1'b1;
    rd(8'h01, 8'h02);
    chk("drive_dir", ddir, 1'b1);
    $display("test reset and lock done");
    shreq = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      d = {i[0], i[2], i[2], i[2:0], ~i[2], i[1]};
      wr(8'h01, d);
      rd(8'h01, d);
      chk("loop", {loop_inv, gq, lref, fb_res, ddir, shut_pol}, d);
      chk("shut", shut_o, i[1]);
    end
    $display("test bias loop done");
    for (i = 0; i < 8; i = i + 1) begin
      d = {1'b0, i[0], 1'b0, i[1], i[2], i[2:0]};
      wr(8'h00, d);
      rd(8'h00, d | 8'h20);
      chk("aux", result, (i < 7) ? src[i] : 10'h000);
      chk("outs", {bias_oe, mod_oe, shut_oe, mod_ref, gpoe}, {i[1], i[1], i[1], i[2], ~i[0]});
      chk("gp_low", gpo, 1'b0);
    end
    @(negedge clk_sys);
    mode = 1'b1;
    rpl = 1'b1;
    #1 chk("gp_pulse", gpoe, 1'b1);
    @(negedge clk_sys);
    rpl = 1'b0;
    #1 chk("gp_pulse", gpoe, 1'b0);
    @(negedge clk_sys);
    mode = 1'b0;
    $display("test output config done");
    wr(8'h00, 8'h1F);
    rd(8'h00, 8'h3F);
    wr(8'h00, 8'h80);
    repeat (3) @(negedge clk_sys);
    rd(8'h00, 8'h20);
    rd(8'h01, 8'hFD);
    $display("test soft reset done");
    complete_run;
  end
endmodule // tb_top
